// [rtl/fspc_map.svh]
// offsets, field positions, reset values and timing counts for the
// fifo status and power control register bank; definitions only
`ifndef FSPC_MAP_SVH
`define FSPC_MAP_SVH

`define FSPC_OFS_RX_DISCARD 8'h78
`define FSPC_OFS_RX_OCC 8'h7C
`define FSPC_OFS_TX_OCC 8'h80
`define FSPC_OFS_PMT 8'h84
`define FSPC_OFS_ENDIAN_TEST 8'h60

`define FSPC_BIT_SKIP 31
`define FSPC_STAT_HI 23
`define FSPC_STAT_LO 16
`define FSPC_CNT_HI 15
`define FSPC_CNT_LO 0
`define FSPC_PM_HI 13
`define FSPC_PM_LO 12
`define FSPC_BIT_PHY_RESET_REQUEST 10
`define FSPC_BIT_WF_EN 9
`define FSPC_BIT_ENERGY_DETECT_ENABLE 8
`define FSPC_BIT_DRV_TYPE 6
`define FSPC_BIT_PULSE 3
`define FSPC_BIT_POL 2
`define FSPC_BIT_OUT_EN 1
`define FSPC_BIT_READY 0

`define FSPC_PM_D0 2'h0
`define FSPC_PM_D1 2'h1
`define FSPC_PM_D2 2'h2
`define FSPC_PM_RSVD 2'h3

`define FSPC_RST_STAT_WORDS 8'h00
`define FSPC_RST_RX_USED 16'h0000
`define FSPC_RST_TX_FREE 16'h1200

`define FSPC_CLK_MHZ 250
`define FSPC_PHY_RESET_REQUEST_US 100
`define FSPC_PHY_RESET_REQUEST_CYC (`FSPC_PHY_RESET_REQUEST_US * `FSPC_CLK_MHZ)
`define FSPC_WAKE_PULSE_MS 50
`define FSPC_WAKE_PULSE_CYC (`FSPC_WAKE_PULSE_MS * 1000 * `FSPC_CLK_MHZ)
`define FSPC_SETTLE_CYC 16

`endif

// [rtl/fspc_pkg.sv]
// types shared by the fifo status and power control register bank
// assumes the map header is included by the design files
package fspc_pkg;
    typedef logic [31:0] fspc_word_t;
    typedef logic [7:0] fspc_addr_t;
    typedef logic [1:0] fspc_pm_t;
    typedef logic [23:0] fspc_count_t;
endpackage

// [rtl/fspc_phy_reset_request.sv]
// phy reset stretcher: holds the reset for a fixed number of cycles
// assumes i_start is a one-cycle pulse on i_clock
`timescale 1ns/1ns
module fspc_phy_reset_request #(
    parameter fspc_pkg::fspc_count_t HOLD_CYCLES = 24'h0061A8
) (
    input wire logic i_clock,   // system clock
    input wire logic i_sys_rst, // sync reset, high
    input wire logic i_start,   // begin a reset hold
    output logic o_busy         // phy held in reset
);
    fspc_pkg::fspc_count_t cnt_ff;
    fspc_pkg::fspc_count_t nxt_cnt;
    logic busy_ff;
    logic nxt_busy;
    wire logic last = (cnt_ff == HOLD_CYCLES - 24'h000001);

    // restart ignored while busy; caller also masks it
    always_comb begin
        nxt_busy = busy_ff;
        nxt_cnt = cnt_ff;
        if (busy_ff) begin
            nxt_cnt = cnt_ff + 24'h000001;
            if (last) begin
                nxt_busy = 1'b0;
                nxt_cnt = 24'h000000;
            end
        end else if (i_start) begin
            nxt_busy = 1'b1;
            nxt_cnt = 24'h000000;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            busy_ff <= 1'b0;
            cnt_ff <= 24'h000000;
        end else begin
            busy_ff <= nxt_busy;
            cnt_ff <= nxt_cnt;
        end
    end

    assign o_busy = busy_ff;
endmodule

// [rtl/fspc_wake_out.sv]
// wake output pin driver: level or timed pulse, open-drain or push-pull
// assumes i_trigger is a one-cycle pulse on i_clock
`timescale 1ns/1ns
module fspc_wake_out #(
    parameter fspc_pkg::fspc_count_t PULSE_CYCLES = 24'hBEBC20
) (
    input wire logic i_clock,      // system clock
    input wire logic i_sys_rst,    // sync reset, high
    input wire logic i_trigger,    // new enabled wake event
    input wire logic i_hold,       // any wake event pending
    input wire logic i_pulse_mode, // pulse rather than level
    input wire logic i_enable,     // pin enabled
    input wire logic i_push_pull,  // push-pull rather than open-drain
    input wire logic i_act_high,   // active high in push-pull
    output logic o_pin,            // pin value
    output logic o_pin_oe_n        // low while driving
);
    fspc_pkg::fspc_count_t cnt_ff;
    logic pulse_ff;
    logic pin_ff;
    logic oe_n_ff;
    wire logic pulse_end = (cnt_ff == PULSE_CYCLES - 24'h000001);
    wire logic active = i_enable & (i_pulse_mode ? pulse_ff : i_hold);
    // open-drain ignores polarity: always pulls low when active
    wire logic nxt_pin = i_push_pull ? (active ~^ i_act_high) : 1'b0;
    wire logic nxt_oe_n = i_push_pull ? 1'b0 : ~active;

    // every event restarts the pulse timer
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            pulse_ff <= 1'b0;
            cnt_ff <= 24'h000000;
        end else if (i_trigger) begin
            pulse_ff <= 1'b1;
            cnt_ff <= 24'h000000;
        end else if (pulse_ff) begin
            pulse_ff <= ~pulse_end;
            cnt_ff <= pulse_end ? 24'h000000 : cnt_ff + 24'h000001;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            pin_ff <= 1'b0;
            oe_n_ff <= 1'b1;
        end else begin
            pin_ff <= nxt_pin;
            oe_n_ff <= nxt_oe_n;
        end
    end

    assign o_pin = pin_ff;
    assign o_pin_oe_n = oe_n_ff;
endmodule

// [rtl/fspc_regs.sv]
// host-visible fifo status and power control registers
// assumes an asynchronous sram-like host bus and same-clock fifo datapath
`timescale 1ns/1ns
`include "fspc_map.svh"
module fspc_regs #(
    parameter fspc_pkg::fspc_count_t PHY_RESET_REQUEST_CYCLES =
        24'(`FSPC_PHY_RESET_REQUEST_CYC),
    parameter fspc_pkg::fspc_count_t WAKE_PULSE_CYCLES =
        24'(`FSPC_WAKE_PULSE_CYC)
) (
    input wire logic i_clock,                 // 250 MHz system clock
    input wire logic i_sys_rst,               // sync reset, high
    input wire logic i_soft_rst,              // soft reset pulse
    input wire logic i_bus_cs_n,              // host chip select, low
    input wire logic i_bus_rd_n,              // host read strobe, low
    input wire logic i_bus_wr_n,              // host write strobe, low
    input wire logic [7:0] i_bus_addr,        // host byte address
    input wire logic [31:0] i_bus_wdata,      // host write data
    output logic [31:0] o_bus_rdata,          // host read data
    output logic o_rx_skip_req,               // start skip, pulse
    input wire logic i_rx_skip_done,          // skip finished, pulse
    input wire logic [7:0] i_rx_status_words, // rx status fifo level
    input wire logic [15:0] i_rx_data_bytes,  // rx data fifo bytes used
    input wire logic [7:0] i_tx_status_words, // tx status fifo level
    input wire logic [15:0] i_tx_data_free,   // tx data fifo bytes free
    output logic [1:0] o_power_state,         // current power state
    output logic o_phy_reset,                 // internal phy reset
    input wire logic i_wake_frame_evt,        // wake frame seen, pulse
    input wire logic i_energy_evt,            // energy detected, pulse
    output logic o_wake_event_interrupt,      // wake interrupt level
    output logic o_wake_event_output,         // wake pin value
    output logic o_wake_event_output_oe_n     // wake pin enable, low
);
    // two-flop synchronisers for every host pin
    logic [42:0] pin_s1_ff;
    logic [42:0] pin_s2_ff;
    logic [1:0] strobe_d_ff;
    wire logic [42:0] pin_raw = {i_bus_cs_n, i_bus_rd_n, i_bus_wr_n,
                                 i_bus_addr, i_bus_wdata};

    wire logic cs_lvl = ~pin_s2_ff[42];
    wire logic rd_lvl = cs_lvl & ~pin_s2_ff[41];
    wire logic wr_lvl = cs_lvl & ~pin_s2_ff[40];
    wire fspc_pkg::fspc_addr_t addr = pin_s2_ff[39:32];
    wire fspc_pkg::fspc_word_t wdata = pin_s2_ff[31:0];
    // one access per strobe: act on its leading edge only
    wire logic rd_pulse = rd_lvl & ~strobe_d_ff[1];
    wire logic wr_pulse = wr_lvl & ~strobe_d_ff[0];

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            pin_s1_ff <= {3'h7, 40'h0000000000};
            pin_s2_ff <= {3'h7, 40'h0000000000};
            strobe_d_ff <= 2'h0;
        end else begin
            pin_s1_ff <= pin_raw;
            pin_s2_ff <= pin_s1_ff;
            strobe_d_ff <= {rd_lvl, wr_lvl};
        end
    end

    wire logic hit_discard = (addr == `FSPC_OFS_RX_DISCARD);
    wire logic hit_rx_occ = (addr == `FSPC_OFS_RX_OCC);
    wire logic hit_tx_occ = (addr == `FSPC_OFS_TX_OCC);
    wire logic hit_pmt = (addr == `FSPC_OFS_PMT);
    wire logic hit_endian = (addr == `FSPC_OFS_ENDIAN_TEST);

    // control state
    logic read_seen_ff;
    logic ready_ff;
    logic [4:0] settle_ff;
    fspc_pkg::fspc_pm_t pstate_ff;
    logic skip_busy_ff;
    logic skip_req_ff;
    logic wf_en_ff;
    logic energy_detect_enable_ff;
    logic drv_pp_ff;
    logic pulse_mode_ff;
    logic pol_high_ff;
    logic out_en_ff;
    logic wf_pend_ff;
    logic ed_pend_ff;
    logic [7:0] rx_stat_ff;
    logic [15:0] rx_used_ff;
    logic [7:0] tx_stat_ff;
    logic [15:0] tx_free_ff;
    fspc_pkg::fspc_word_t rdata_ff;
    logic phy_busy;

    wire logic reduced = (pstate_ff != `FSPC_PM_D0);
    wire logic wake_req = wr_pulse & hit_endian & reduced;
    // only endian test while not ready
    wire logic wr_ok = wr_pulse & read_seen_ff & ready_ff;
    wire logic wr_discard = wr_ok & hit_discard;
    wire logic wr_pmt = wr_ok & hit_pmt;
    wire fspc_pkg::fspc_pm_t pm_req = wdata[`FSPC_PM_HI:`FSPC_PM_LO];
    wire logic enter_low = wr_pmt & (pm_req != `FSPC_PM_D0)
                           & (pm_req != `FSPC_PM_RSVD);
    wire logic skip_start = wr_discard & wdata[`FSPC_BIT_SKIP]
                            & ~skip_busy_ff;
    // ignored while phy reset reads one
    wire logic phy_start = wr_pmt & wdata[`FSPC_BIT_PHY_RESET_REQUEST] & ~phy_busy;
    wire logic settle_done = (settle_ff == 5'(`FSPC_SETTLE_CYC - 1));
    wire logic wf_hit = i_wake_frame_evt & wf_en_ff;
    wire logic ed_hit = i_energy_evt & energy_detect_enable_ff;

    // ready after settle time from power-up or wake
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            ready_ff <= 1'b0;
            settle_ff <= 5'h00;
        end else if (enter_low) begin
            ready_ff <= 1'b0;
            settle_ff <= 5'h00;
        end else if (!ready_ff && !reduced) begin
            ready_ff <= settle_done;
            settle_ff <= settle_done ? 5'h00 : settle_ff + 5'h01;
        end
    end

    // state change on write; field reads back 00b
    always_ff @(posedge i_clock) begin
        if (i_sys_rst || i_soft_rst) begin
            pstate_ff <= `FSPC_PM_D0;
        end else if (wake_req) begin
            pstate_ff <= `FSPC_PM_D0;
        end else if (enter_low) begin
            pstate_ff <= pm_req;
        end
    end

    // one read needed after reset and after wake
    always_ff @(posedge i_clock) begin
        if (i_sys_rst || i_soft_rst || wake_req || enter_low) begin
            read_seen_ff <= 1'b0;
        end else if (rd_pulse) begin
            read_seen_ff <= 1'b1;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst || i_soft_rst) begin
            skip_busy_ff <= 1'b0;
            skip_req_ff <= 1'b0;
        end else begin
            skip_req_ff <= skip_start;
            if (skip_start) begin
                skip_busy_ff <= 1'b1;
            end else if (i_rx_skip_done) begin
                skip_busy_ff <= 1'b0;
            end
        end
    end

    // wake controls cleared by soft reset
    always_ff @(posedge i_clock) begin
        if (i_sys_rst || i_soft_rst) begin
            wf_en_ff <= 1'b0;
            energy_detect_enable_ff <= 1'b0;
            pulse_mode_ff <= 1'b0;
            out_en_ff <= 1'b0;
        end else if (wr_pmt) begin
            wf_en_ff <= wdata[`FSPC_BIT_WF_EN];
            energy_detect_enable_ff <= wdata[`FSPC_BIT_ENERGY_DETECT_ENABLE];
            pulse_mode_ff <= wdata[`FSPC_BIT_PULSE];
            out_en_ff <= wdata[`FSPC_BIT_OUT_EN];
        end
    end

    // driver type and polarity survive soft reset
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            drv_pp_ff <= 1'b0;
            pol_high_ff <= 1'b0;
        end else if (wr_pmt) begin
            drv_pp_ff <= wdata[`FSPC_BIT_DRV_TYPE];
            pol_high_ff <= wdata[`FSPC_BIT_POL];
        end
    end

    // wake frame and energy pending
    // pending drops only by clearing its enable or by a reset; a new event wins
    always_ff @(posedge i_clock) begin
        if (i_sys_rst || i_soft_rst) begin
            wf_pend_ff <= 1'b0;
            ed_pend_ff <= 1'b0;
        end else begin
            wf_pend_ff <= wf_hit | (wf_pend_ff & wf_en_ff
                          & ~(wr_pmt & ~wdata[`FSPC_BIT_WF_EN]));
            ed_pend_ff <= ed_hit | (ed_pend_ff & energy_detect_enable_ff
                          & ~(wr_pmt & ~wdata[`FSPC_BIT_ENERGY_DETECT_ENABLE]));
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            rx_stat_ff <= `FSPC_RST_STAT_WORDS;
            rx_used_ff <= `FSPC_RST_RX_USED;
            tx_stat_ff <= `FSPC_RST_STAT_WORDS;
            tx_free_ff <= `FSPC_RST_TX_FREE;
        end else begin
            rx_stat_ff <= i_rx_status_words;
            rx_used_ff <= i_rx_data_bytes;
            tx_stat_ff <= i_tx_status_words;
            tx_free_ff <= i_tx_data_free;
        end
    end

    wire fspc_pkg::fspc_word_t rd_discard = {skip_busy_ff, 31'h00000000};
    wire fspc_pkg::fspc_word_t rd_rx_occ = {8'h00, rx_stat_ff, rx_used_ff};
    wire fspc_pkg::fspc_word_t rd_tx_occ = {8'h00, tx_stat_ff, tx_free_ff};
    wire fspc_pkg::fspc_word_t rd_pmt = {18'h00000, 2'h0, 1'b0, phy_busy,
                                         wf_en_ff, energy_detect_enable_ff, 1'b0,
                                         drv_pp_ff, 2'h0, pulse_mode_ff,
                                         pol_high_ff, out_en_ff, ready_ff};
    // power control answers in every state
    wire fspc_pkg::fspc_word_t rd_mux =
        hit_discard ? rd_discard :
        hit_rx_occ ? rd_rx_occ :
        hit_tx_occ ? rd_tx_occ :
        hit_pmt ? rd_pmt : 32'h00000000;

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            rdata_ff <= 32'h00000000;
        end else if (rd_pulse) begin
            rdata_ff <= rd_mux;
        end
    end

    // phy held in reset for the full hold time
    fspc_phy_reset_request #(
        .HOLD_CYCLES(PHY_RESET_REQUEST_CYCLES)
    ) u_phy_reset_request (
        .i_clock(i_clock),
        .i_sys_rst(i_sys_rst),
        .i_start(phy_start),
        .o_busy(phy_busy)
    );

    fspc_wake_out #(
        .PULSE_CYCLES(WAKE_PULSE_CYCLES)
    ) u_wake_out (
        .i_clock(i_clock),
        .i_sys_rst(i_sys_rst),
        .i_trigger(wf_hit | ed_hit),
        .i_hold(wf_pend_ff | ed_pend_ff),
        .i_pulse_mode(pulse_mode_ff),
        .i_enable(out_en_ff),
        .i_push_pull(drv_pp_ff),
        .i_act_high(pol_high_ff),
        .o_pin(o_wake_event_output),
        .o_pin_oe_n(o_wake_event_output_oe_n)
    );

    assign o_bus_rdata = rdata_ff;
    assign o_rx_skip_req = skip_req_ff;
    assign o_power_state = pstate_ff;
    assign o_phy_reset = phy_busy;
    // interrupt independent of the pin enable
    assign o_wake_event_interrupt = wf_pend_ff | ed_pend_ff;
endmodule

// [dv/fspc_regs_props.sv]
// concurrent checks on the fifo status and power control register ports
// assumes it is bound to fspc_regs and sees only that module's ports
`timescale 1ns/1ns
module fspc_regs_props #(
    parameter fspc_pkg::fspc_count_t PHY_RESET_REQUEST_CYCLES = 24'h000028,
    parameter fspc_pkg::fspc_count_t WAKE_PULSE_CYCLES = 24'h00001E
) (
    input wire logic i_clock,                  // system clock
    input wire logic i_sys_rst,                // sync reset, high
    input wire logic i_soft_rst,               // soft reset pulse
    input wire logic i_bus_cs_n,               // chip select, low
    input wire logic i_bus_rd_n,               // read strobe, low
    input wire logic i_bus_wr_n,               // write strobe, low
    input wire logic [31:0] o_bus_rdata,       // read data
    input wire logic o_rx_skip_req,            // skip request
    input wire logic i_rx_skip_done,           // skip finished
    input wire logic [1:0] o_power_state,      // power state
    input wire logic o_phy_reset,              // phy reset
    input wire logic i_wake_frame_evt,         // wake frame event
    input wire logic i_energy_evt,             // energy event
    input wire logic o_wake_event_interrupt,   // wake interrupt
    input wire logic o_wake_event_output_oe_n  // wake pin enable
);
    fspc_pkg::fspc_count_t phy_cnt_ff;
    logic skip_busy_ff;

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);

    always_ff @(posedge i_clock) begin
        if (i_sys_rst || !o_phy_reset) begin
            phy_cnt_ff <= 24'h000000;
        end else begin
            phy_cnt_ff <= phy_cnt_ff + 24'h000001;
        end
    end

    // soft reset drops a skip in flight, so a new one is legal after it
    always_ff @(posedge i_clock) begin
        if (i_sys_rst || i_soft_rst || i_rx_skip_done) begin
            skip_busy_ff <= 1'b0;
        end else if (o_rx_skip_req) begin
            skip_busy_ff <= 1'b1;
        end
    end

    sequence s_skip_issue;
        o_rx_skip_req ##1 !o_rx_skip_req;
    endsequence
    sequence s_phy_end;
        $fell(o_phy_reset);
    endsequence

    a_skip_one_pulse: assert property (
        o_rx_skip_req |-> s_skip_issue)
        else $error("skip request longer than one cycle");
    a_skip_no_retrigger: assert property (
        o_rx_skip_req |-> !skip_busy_ff)
        else $error("skip request while skip still busy");
    a_phy_hold_len: assert property (
        s_phy_end |-> phy_cnt_ff == PHY_RESET_REQUEST_CYCLES)
        else $error("phy reset held for wrong length");
    a_phy_write_cause: assert property (
        $rose(o_phy_reset) |-> $past(!i_bus_cs_n && !i_bus_wr_n))
        else $error("phy reset started without a host write");
    a_power_legal: assert property (
        o_power_state != 2'h3)
        else $error("reserved power state entered");
    a_power_cause: assert property (
        $changed(o_power_state)
        |-> $past((!i_bus_cs_n && !i_bus_wr_n) || i_soft_rst))
        else $error("power state moved without a write");
    a_low_from_normal: assert property (
        $changed(o_power_state) && o_power_state != 2'h0
        |-> $past(o_power_state) == 2'h0)
        else $error("low power entered from low power");
    a_int_event_cause: assert property (
        $rose(o_wake_event_interrupt)
        |-> $past(i_wake_frame_evt || i_energy_evt))
        else $error("wake interrupt without an event");
    a_rdata_read_cause: assert property (
        $changed(o_bus_rdata) |-> $past(!i_bus_cs_n && !i_bus_rd_n))
        else $error("read data moved without a read");
    a_reset_idle_out: assert property (
        $fell(i_sys_rst) |-> o_wake_event_output_oe_n
        && !o_phy_reset && !o_wake_event_interrupt)
        else $error("outputs not idle after reset");
endmodule

bind fspc_regs fspc_regs_props #(
    .PHY_RESET_REQUEST_CYCLES(PHY_RESET_REQUEST_CYCLES),
    .WAKE_PULSE_CYCLES(WAKE_PULSE_CYCLES)
) fspc_regs_props_inst (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_soft_rst(i_soft_rst),
    .i_bus_cs_n(i_bus_cs_n), .i_bus_rd_n(i_bus_rd_n),
    .i_bus_wr_n(i_bus_wr_n), .o_bus_rdata(o_bus_rdata),
    .o_rx_skip_req(o_rx_skip_req), .i_rx_skip_done(i_rx_skip_done),
    .o_power_state(o_power_state), .o_phy_reset(o_phy_reset),
    .i_wake_frame_evt(i_wake_frame_evt), .i_energy_evt(i_energy_evt),
    .o_wake_event_interrupt(o_wake_event_interrupt),
    .o_wake_event_output_oe_n(o_wake_event_output_oe_n)
);

// [dv/fspc_host_model.sv]
// host processor model issuing sram-like register accesses
// assumes the device synchronises strobes through two flops
`timescale 1ns/1ns
module fspc_host_model (
    input wire logic i_clock,            // system clock
    input wire logic [31:0] i_bus_rdata, // read data
    output logic o_bus_cs_n,             // chip select, low
    output logic o_bus_rd_n,             // read strobe, low
    output logic o_bus_wr_n,             // write strobe, low
    output logic [7:0] o_bus_addr,       // byte address
    output logic [31:0] o_bus_wdata      // write data
);
    // strobe outlasts sync plus answer edge; gap outlasts sync too
    localparam int HOLD = 6;
    localparam int GAP = 4;

    initial begin
        o_bus_cs_n = 1'b1;
        o_bus_rd_n = 1'b1;
        o_bus_wr_n = 1'b1;
        o_bus_addr = 8'h00;
        o_bus_wdata = 32'h00000000;
    end

    // only register words, never fifo data ports
    task automatic access(input fspc_pkg::fspc_addr_t a,
            input fspc_pkg::fspc_word_t d, input logic is_rd,
            output fspc_pkg::fspc_word_t q);
        @(posedge i_clock);
        #1;
        o_bus_addr = a;
        o_bus_wdata = d;
        o_bus_cs_n = 1'b0;
        o_bus_rd_n = !is_rd;
        o_bus_wr_n = is_rd;
        repeat (HOLD) @(posedge i_clock);
        q = i_bus_rdata;
        #1;
        o_bus_cs_n = 1'b1;
        o_bus_rd_n = 1'b1;
        o_bus_wr_n = 1'b1;
        o_bus_wdata = ~d;
        repeat (GAP) @(posedge i_clock);
        #1;
    endtask

    // callers read first and write once ready, bar the endian wake and the write right after soft reset
    task automatic bus_write(input fspc_pkg::fspc_addr_t a,
            input fspc_pkg::fspc_word_t d);
        fspc_pkg::fspc_word_t q;
        access(a, d, 1'b0, q);
    endtask

    task automatic bus_read(input fspc_pkg::fspc_addr_t a,
            output fspc_pkg::fspc_word_t q);
        access(a, 32'h5A5A5A5A, 1'b1, q);
    endtask
endmodule

// [dv/tb_top.sv]
// self-checking bench for the fifo status and power control registers
// assumes the map header is on the include path
`timescale 1ns/1ns
`include "fspc_map.svh"
module tb_top;
    logic clock, sys_rst, soft_rst, skip_done, wf_evt, ed_evt;
    logic cs_n, rd_n, wr_n, skip_req, phy_reset_request, wake_int, wake_pin, wake_oe_n;
    logic [7:0] addr, rx_sw, tx_sw;
    logic [15:0] rx_db, tx_df;
    logic [31:0] wdata, rdata, rd;
    logic [1:0] pstate;
    int failures, checks, skip_cnt;

    fspc_regs #(.PHY_RESET_REQUEST_CYCLES(24'h000028),
        .WAKE_PULSE_CYCLES(24'h00001E)) fspc_regs_inst (
        .i_clock(clock), .i_sys_rst(sys_rst), .i_soft_rst(soft_rst),
        .i_bus_cs_n(cs_n), .i_bus_rd_n(rd_n), .i_bus_wr_n(wr_n),
        .i_bus_addr(addr), .i_bus_wdata(wdata), .o_bus_rdata(rdata),
        .o_rx_skip_req(skip_req), .i_rx_skip_done(skip_done),
        .i_rx_status_words(rx_sw), .i_rx_data_bytes(rx_db),
        .i_tx_status_words(tx_sw), .i_tx_data_free(tx_df),
        .o_power_state(pstate), .o_phy_reset(phy_reset_request),
        .i_wake_frame_evt(wf_evt), .i_energy_evt(ed_evt),
        .o_wake_event_interrupt(wake_int), .o_wake_event_output(wake_pin),
        .o_wake_event_output_oe_n(wake_oe_n));
    fspc_host_model fspc_host_model_inst (.i_clock(clock),
        .i_bus_rdata(rdata), .o_bus_cs_n(cs_n), .o_bus_rd_n(rd_n),
        .o_bus_wr_n(wr_n), .o_bus_addr(addr), .o_bus_wdata(wdata));

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    always @(posedge clock) if (skip_req === 1'b1) skip_cnt++;

    task tally_and_finish;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task check_word(input string what, input logic [31:0] exp,
            input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        fspc_host_model_inst.bus_write(a, d);
    endtask
    task rd_check(input string what, input logic [7:0] a,
            input logic [31:0] exp);
        fspc_host_model_inst.bus_read(a, rd);
        check_word(what, exp, rd);
    endtask
    task wait_ready;
        rd = 32'h00000000;
        for (int n = 0; n < 8 && rd[0] !== 1'b1; n++) begin
            fspc_host_model_inst.bus_read(`FSPC_OFS_PMT, rd);
        end
        check_word("ready", 32'h00000001, {31'h0, rd[0]});
    endtask
    task t_levels;
        rd_check("rx occ reset", `FSPC_OFS_RX_OCC, 32'h00000000);
        rd_check("tx occ reset", `FSPC_OFS_TX_OCC, 32'h00001200);
        rx_sw = 8'hA5;
        rx_db = 16'h5A3C;
        tx_sw = 8'h81;
        tx_df = 16'h0FFC;
        cyc(2);
        rd_check("rx occ", `FSPC_OFS_RX_OCC, 32'h00A55A3C);
        rd_check("tx occ", `FSPC_OFS_TX_OCC, 32'h00810FFC);
        rd_check("unmapped", 8'h90, 32'h00000000);
        $display("test levels done");
    endtask
    task t_skip;
        wr(`FSPC_OFS_RX_DISCARD, 32'hFFFFFFFF);
        rd_check("skip busy", `FSPC_OFS_RX_DISCARD, 32'h80000000);
        wr(`FSPC_OFS_RX_DISCARD, 32'h80000000);
        check_word("skip reqs", 32'h00000001, 32'(skip_cnt));
        cyc(1);
        skip_done = 1'b1;
        cyc(1);
        skip_done = 1'b0;
        cyc(1);
        rd_check("skip over", `FSPC_OFS_RX_DISCARD, 32'h00000000);
        $display("test skip done");
    endtask
    task t_phy;
        wr(`FSPC_OFS_PMT, 32'h00000400);
        check_word("phy on", 32'h00000001, {31'h0, phy_reset_request});
        rd_check("phy bit", `FSPC_OFS_PMT, 32'h00000401);
        wr(`FSPC_OFS_PMT, 32'h00000400);
        cyc(20);
        check_word("phy off", 32'h00000000, {31'h0, phy_reset_request});
        rd_check("phy clear", `FSPC_OFS_PMT, 32'h00000001);
        $display("test phy done");
    endtask
    task pin_check(input string what, input logic [2:0] exp);
        check_word(what, {29'h0, exp}, {29'h0, wake_int, wake_pin, wake_oe_n});
    endtask
    task t_wake;
        wr(`FSPC_OFS_PMT, 32'h00000346);
        rd_check("wake cfg", `FSPC_OFS_PMT, 32'h00000347);
        wf_evt = 1'b1;
        cyc(1);
        wf_evt = 1'b0;
        cyc(3);
        pin_check("frame wake", 3'b110);
        wr(`FSPC_OFS_PMT, 32'h00000142);
        pin_check("low idle", 3'b010);
        ed_evt = 1'b1;
        cyc(1);
        ed_evt = 1'b0;
        cyc(3);
        pin_check("energy low", 3'b100);
        wr(`FSPC_OFS_PMT, 32'h0000010A);
        ed_evt = 1'b1;
        cyc(1);
        ed_evt = 1'b0;
        cyc(3);
        check_word("od drive", 32'h00000000, {30'h0, wake_pin, wake_oe_n});
        cyc(40);
        check_word("pulse end", 32'h00000003, {30'h0, wake_int, wake_oe_n});
        wr(`FSPC_OFS_PMT, 32'h00000108);
        check_word("int kept", 32'h00000003, {30'h0, wake_int, wake_oe_n});
        wr(`FSPC_OFS_PMT, 32'h00000000);
        check_word("int clear", 32'h00000000, {31'h0, wake_int});
        $display("test wake done");
    endtask
    task t_power;
        for (int s = 1; s < 3; s++) begin
            wr(`FSPC_OFS_PMT, 32'(s) << 12);
            check_word("low state", 32'(s), {30'h0, pstate});
            rd_check("low read", `FSPC_OFS_PMT, 32'h00000000);
            wr(`FSPC_OFS_ENDIAN_TEST, 32'h12345678);
            check_word("woken", 32'h00000000, {30'h0, pstate});
            wait_ready;
        end
        wr(`FSPC_OFS_PMT, 32'h00003000);
        check_word("rsvd state", 32'h00000000, {30'h0, pstate});
        $display("test power done");
    endtask
    task t_soft;
        wr(`FSPC_OFS_PMT, 32'h00000246);
        soft_rst = 1'b1;
        cyc(1);
        soft_rst = 1'b0;
        wr(`FSPC_OFS_PMT, 32'h00000202);
        rd_check("soft kept", `FSPC_OFS_PMT, 32'h00000045);
        wr(`FSPC_OFS_PMT, 32'h00000002);
        rd_check("after read", `FSPC_OFS_PMT, 32'h00000003);
        $display("test soft reset done");
    endtask

    initial begin
        repeat (20000) @(posedge clock);
        failures++;
        tally_and_finish;
    end
    initial begin
        {sys_rst, soft_rst, skip_done, wf_evt, ed_evt} = 5'b10000;
        {rx_sw, rx_db, tx_sw} = 32'h00000000;
        tx_df = 16'h1200;
        repeat (10) @(posedge clock);
        #1;
        sys_rst = 1'b0;
        wait_ready;
        t_levels;
        t_skip;
        t_phy;
        t_wake;
        t_power;
        t_soft;
        tally_and_finish;
    end
endmodule
